// ---- rcs_regs_cfg.svh ----
// Address map, field positions, reset values and widths of the result, tally and supply registers.
`ifndef RCS_REGS_CFG_SVH
`define RCS_REGS_CFG_SVH

`define RCS_ADDR_WIDTH 8
`define RCS_DATA_WIDTH 16
`define RCS_TALLY_WIDTH 32
`define RCS_CONV_WIDTH 24
`define RCS_NUM_CHANNELS 4

`define RCS_ADDR_LAST_UPPER 8'h4D
`define RCS_ADDR_LAST_LOW 8'h4E
`define RCS_ADDR_TALLY_UPPER_A 8'h4F
`define RCS_ADDR_TALLY_LOWER_A 8'h50
`define RCS_ADDR_TALLY_UPPER_D 8'h55
`define RCS_ADDR_TALLY_LOWER_D 8'h56
`define RCS_ADDR_SUPPLY_STATUS 8'h57

`define RCS_BIT_HIGH_SIDE 6
`define RCS_BIT_LOW_SIDE 5
`define RCS_BIT_OUT_SUPPLY 4
`define RCS_BIT_CORE 3
`define RCS_BIT_DIGITAL 2
`define RCS_BIT_NEGATIVE 1
`define RCS_BIT_CAL_MEM 0
`define RCS_STATUS_USED 7

`define RCS_RESET_DATA 16'h0000
`define RCS_RESET_CONV 24'h00_0000
`define RCS_RESET_TALLY 32'h0000_0000

`endif

// ---- rcs_pkg.sv ----
// Types shared by the result, tally and supply status register bank.
`default_nettype none
`include "rcs_regs_cfg.svh"

package rcs_pkg;

    typedef struct packed {
        logic read;
        logic write;
        logic [`RCS_ADDR_WIDTH-1:0] addr;
        logic [`RCS_DATA_WIDTH-1:0] wdata;
    } rcs_reg_req_t;

    typedef struct packed {
        logic isDiag;
        logic [2:0] source;
        logic [`RCS_CONV_WIDTH-1:0] value;
    } rcs_conv_result_t;

    // Bit order matches status bits 6 down to 1.
    typedef struct packed {
        logic analog_supply_high_side_fault;
        logic analog_supply_low_side_fault;
        logic outputSupplyFault;
        logic analog_core_supply_fault;
        logic digital_supply_fault;
        logic negative_supply_fault;
    } rcs_supply_flags_t;

endpackage

`default_nettype wire

// ---- rcs_regs.sv ----
// Register bank for last conversion result, input edge tallies and sticky supply status.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs_cfg.svh"

// How it works
// - Low result word shows bits 15..0 of the latest conversion, channel or diagnostic.
// - Upper word read first; low word held from that read until the low word is read.
// - Diagnostic results read with zero in the upper eight result bits.
// - Each channel has a 32-bit tally, upper and lower halves readable.
// - A tally counts only while its enable is set, otherwise stays frozen.
// - A tally past full scale wraps to zero silently and keeps counting.
// - Comparator invert flips the level so the opposite edge counts.
// - Analog supply undervoltage sets high-side bit 6 and low-side bit 5.
// - Output supply low sets bit 4; analog core supply low sets bit 3.
// - Negative supply rising too high sets bit 1.
// - Digital supply low sets bit 2; write-one clears it, set preferred.
// - Calibration memory checksum or uncorrectable fault on load sets bit 0.
// - Any register access before calibration refresh ends also sets bit 0.
// - Write-one clears bit 0 when its only cause was a premature access.
// - A real calibration memory fault keeps bit 0 set despite write-one.
module rcs_regs
    import rcs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset_n,
    // Register access from the serial interface decoder.
    input wire rcs_reg_req_t regReq,
    output logic [`RCS_DATA_WIDTH-1:0] readData,
    output logic readValid,
    // Converter result.
    input wire logic convDone,
    input wire rcs_conv_result_t convResult,
    // Digital input channels.
    input wire logic [`RCS_NUM_CHANNELS-1:0] deglitchedComp,
    input wire logic [`RCS_NUM_CHANNELS-1:0] countEnable,
    input wire logic [`RCS_NUM_CHANNELS-1:0] comparator_invert,
    // Supply monitors and calibration memory.
    input wire rcs_supply_flags_t supplyFlags,
    input wire logic calMemFault,
    input wire logic calMemRefreshDone
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    function automatic logic isTallyAddr(input logic [`RCS_ADDR_WIDTH-1:0] a);
        return (a >= `RCS_ADDR_TALLY_UPPER_A) && (a <= `RCS_ADDR_TALLY_LOWER_D);
    endfunction

    function automatic logic [1:0] tallyChannel(input logic [`RCS_ADDR_WIDTH-1:0] a);
        logic [`RCS_ADDR_WIDTH-1:0] delta;
        delta = a - `RCS_ADDR_TALLY_UPPER_A;
        return delta[2:1];
    endfunction

    function automatic logic isTallyUpper(input logic [`RCS_ADDR_WIDTH-1:0] a);
        logic [`RCS_ADDR_WIDTH-1:0] delta;
        delta = a - `RCS_ADDR_TALLY_UPPER_A;
        return ~delta[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Last conversion result and the upper-then-low read pairing.

    rcs_conv_result_t latest_conversion_value;
    logic [`RCS_DATA_WIDTH-1:0] heldLow;
    logic holdValid;
    logic readUpper;
    logic readLow;

    assign readUpper = regReq.read && (regReq.addr == `RCS_ADDR_LAST_UPPER);
    assign readLow = regReq.read && (regReq.addr == `RCS_ADDR_LAST_LOW);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latest_conversion_value <= '0;
        end else if (convDone) begin
            latest_conversion_value <= convResult;
        end
    end

    // A conversion landing between the two reads must not tear the 24-bit value.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            heldLow <= `RCS_RESET_DATA;
            holdValid <= 1'b0;
        end else if (readUpper) begin
            heldLow <= latest_conversion_value.value[15:0];
            holdValid <= 1'b1;
        end else if (readLow) begin
            holdValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input edge tallies.

    logic [`RCS_TALLY_WIDTH-1:0] input_edge_tally [`RCS_NUM_CHANNELS];
    logic [`RCS_NUM_CHANNELS-1:0] prevLevel;
    logic [`RCS_NUM_CHANNELS-1:0] countLevel;
    logic [`RCS_NUM_CHANNELS-1:0] countEdge;

    assign countLevel = deglitchedComp ^ comparator_invert;
    assign countEdge = countLevel & ~prevLevel;

    // Toggling the invert setting looks like an edge; software should do it with counting off.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prevLevel <= '0;
        end else begin
            prevLevel <= countLevel;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `RCS_NUM_CHANNELS; i++) begin
                input_edge_tally[i] <= `RCS_RESET_TALLY;
            end
        end else begin
            for (int i = 0; i < `RCS_NUM_CHANNELS; i++) begin
                // Plain modulo add: full scale rolls to zero with no flag.
                if (countEnable[i] && countEdge[i]) begin
                    input_edge_tally[i] <= input_edge_tally[i] + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply and calibration memory status.

    logic [`RCS_STATUS_USED-1:1] supplySticky;
    logic calFaultSticky;
    logic prematureAccess;
    logic statusWrite;
    logic anyAccess;
    logic [`RCS_STATUS_USED-1:1] supplySet;

    assign statusWrite = regReq.write && (regReq.addr == `RCS_ADDR_SUPPLY_STATUS);
    assign anyAccess = regReq.read || regReq.write;
    assign supplySet = supplyFlags;

    // Set wins over a write-one clear arriving in the same cycle.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            supplySticky <= '0;
        end else begin
            supplySticky <= (supplySticky & ~({`RCS_STATUS_USED-1{statusWrite}}
                & regReq.wdata[`RCS_STATUS_USED-1:1])) | supplySet;
        end
    end

    // A genuine memory fault is never cleared by software; only reset removes it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            calFaultSticky <= 1'b0;
        end else if (calMemFault) begin
            calFaultSticky <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prematureAccess <= 1'b0;
        end else if (anyAccess && !calMemRefreshDone) begin
            prematureAccess <= 1'b1;
        end else if (statusWrite && regReq.wdata[`RCS_BIT_CAL_MEM]) begin
            prematureAccess <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port.

    logic [`RCS_DATA_WIDTH-1:0] next_readData;
    logic [`RCS_TALLY_WIDTH-1:0] tallySel;

    always_comb begin
        next_readData = `RCS_RESET_DATA;
        tallySel = input_edge_tally[tallyChannel(regReq.addr)];
        if (regReq.addr == `RCS_ADDR_LAST_UPPER) begin
            next_readData[10:8] = latest_conversion_value.source;
            if (!latest_conversion_value.isDiag) begin
                next_readData[7:0] = latest_conversion_value.value[23:16];
            end
        end else if (regReq.addr == `RCS_ADDR_LAST_LOW) begin
            next_readData = holdValid ? heldLow
                : latest_conversion_value.value[15:0];
        end else if (isTallyAddr(regReq.addr)) begin
            next_readData = isTallyUpper(regReq.addr) ? tallySel[31:16]
                : tallySel[15:0];
        end else if (regReq.addr == `RCS_ADDR_SUPPLY_STATUS) begin
            next_readData[`RCS_STATUS_USED-1:1] = supplySticky;
            next_readData[`RCS_BIT_CAL_MEM] = calFaultSticky | prematureAccess;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readData <= `RCS_RESET_DATA;
            readValid <= 1'b0;
        end else begin
            readValid <= regReq.read;
            if (regReq.read) begin
                readData <= next_readData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_diagUpperZero;
        @(posedge clock) disable iff (!reset_n)
        readUpper && latest_conversion_value.isDiag |=> readValid && readData[7:0] == 8'h00;
    endproperty
    a_diagUpperZero: assert property (p_diagUpperZero)
        else $error("diag upper bits not zero");

    property p_pairedLow;
        @(posedge clock) disable iff (!reset_n)
        readUpper ##1 readLow |=> readData == $past(latest_conversion_value.value[15:0], 2);
    endproperty
    a_pairedLow: assert property (p_pairedLow)
        else $error("low word not held from upper read");

    property p_liveLow;
        @(posedge clock) disable iff (!reset_n)
        readLow && !holdValid |=> readData == $past(latest_conversion_value.value[15:0]);
    endproperty
    a_liveLow: assert property (p_liveLow)
        else $error("low word not latest result");

    property p_frozen;
        @(posedge clock) disable iff (!reset_n)
        !countEnable[0] |=> $stable(input_edge_tally[0]);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("tally moved while disabled");

    property p_increment;
        @(posedge clock) disable iff (!reset_n)
        countEnable[0] && (deglitchedComp[0] ^ comparator_invert[0]) && !prevLevel[0]
        |=> input_edge_tally[0] == $past(input_edge_tally[0]) + 1'b1;
    endproperty
    a_increment: assert property (p_increment)
        else $error("tally missed an edge");

    property p_wrap;
        @(posedge clock) disable iff (!reset_n)
        countEnable[0] && countEdge[0] && (&input_edge_tally[0]) |=> input_edge_tally[0] == '0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("tally did not wrap to zero");

    property p_supplySet;
        @(posedge clock) disable iff (!reset_n)
        supplyFlags.analog_supply_high_side_fault ##1 regReq.read
        && regReq.addr == `RCS_ADDR_SUPPLY_STATUS |=> readData[`RCS_BIT_HIGH_SIDE];
    endproperty
    a_supplySet: assert property (p_supplySet)
        else $error("supply fault bit not set");

    property p_premature;
        @(posedge clock) disable iff (!reset_n)
        anyAccess && !calMemRefreshDone |=> prematureAccess;
    endproperty
    a_premature: assert property (p_premature)
        else $error("early access not flagged");

    property p_realFaultStays;
        @(posedge clock) disable iff (!reset_n)
        calFaultSticky |=> calFaultSticky ##1 calFaultSticky;
    endproperty
    a_realFaultStays: assert property (p_realFaultStays)
        else $error("memory fault cleared");

    property p_reservedZero;
        @(posedge clock) disable iff (!reset_n)
        regReq.read && regReq.addr == `RCS_ADDR_SUPPLY_STATUS |=> readData[15:7] == 9'h000;
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("reserved bits not zero");

    property p_calMemSet;
        @(posedge clock) disable iff (!reset_n)
        calMemFault |=> calFaultSticky;
    endproperty
    a_calMemSet: assert property (p_calMemSet)
        else $error("memory fault not flagged");

    property p_prematureClear;
        @(posedge clock) disable iff (!reset_n)
        statusWrite && regReq.wdata[`RCS_BIT_CAL_MEM] && calMemRefreshDone |=> !prematureAccess;
    endproperty
    a_prematureClear: assert property (p_prematureClear)
        else $error("early access flag not cleared");

    property p_tallyLow;
        @(posedge clock) disable iff (!reset_n)
        regReq.read && regReq.addr == `RCS_ADDR_TALLY_LOWER_A
        |=> readData == $past(input_edge_tally[0][15:0]);
    endproperty
    a_tallyLow: assert property (p_tallyLow)
        else $error("lower tally half not returned");

endmodule // rcs_regs

`default_nettype wire

// ---- rcs_host_model.sv ----
// Host controller model that issues register reads and writes to the bank.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs_cfg.svh"

module rcs_host_model
    import rcs_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Register port.
    output var rcs_reg_req_t regReq,
    input wire logic [`RCS_DATA_WIDTH-1:0] readData,
    input wire logic readValid
);

    initial regReq = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Requests launch on the falling edge so the bank samples settled values.
    // Callers issue nothing until the reset wait has passed.
    // The low word is read after the upper word or on its own once a result is ready.
    // Tallies are polled after only a few edges, far below any wrap.
    task automatic reg_read(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        @(negedge clock);
        regReq.read = 1'b1;
        regReq.addr = addr;
        @(negedge clock);
        ok = readValid;
        data = readData;
        regReq.read = 1'b0;
    endtask

    // Upper then low result word in back-to-back cycles, the strobe held high across both.
    task automatic reg_read_pair(output logic [15:0] upper, output logic [15:0] low);
        @(negedge clock);
        regReq.read = 1'b1;
        regReq.addr = `RCS_ADDR_LAST_UPPER;
        @(negedge clock);
        upper = readData;
        regReq.addr = `RCS_ADDR_LAST_LOW;
        @(negedge clock);
        low = readData;
        regReq.read = 1'b0;
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
        @(negedge clock);
        regReq.write = 1'b1;
        regReq.addr = addr;
        regReq.wdata = data;
        @(negedge clock);
        regReq.write = 1'b0;
    endtask

endmodule // rcs_host_model

`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the result, tally and supply status register bank.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs_cfg.svh"

module testbench;
    import rcs_pkg::*;

    logic clock = 1'b0;
    logic reset_n = 1'b0;
    rcs_reg_req_t regReq;
    logic [15:0] readData;
    logic readValid;
    logic convDone = 1'b0;
    rcs_conv_result_t convResult = '0;
    logic [3:0] deglitchedComp = 4'h0;
    logic [3:0] countEnable = 4'h0;
    logic [3:0] comparator_invert = 4'h0;
    rcs_supply_flags_t supplyFlags = '0;
    logic calMemFault = 1'b0;
    logic calMemRefreshDone = 1'b1;
    int bad_count = 0;
    int n_compared = 0;

    always #25 clock = ~clock;

    rcs_regs uut (.clock(clock), .reset_n(reset_n), .regReq(regReq), .readData(readData),
        .readValid(readValid), .convDone(convDone), .convResult(convResult),
        .deglitchedComp(deglitchedComp), .countEnable(countEnable),
        .comparator_invert(comparator_invert), .supplyFlags(supplyFlags),
        .calMemFault(calMemFault), .calMemRefreshDone(calMemRefreshDone));

    rcs_host_model host (.clock(clock), .regReq(regReq), .readData(readData),
        .readValid(readValid));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic expect_rd(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.reg_read(a, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, exp);
    endtask

    task automatic do_reset;
        @(negedge clock);
        reset_n = 1'b0;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
    endtask

    task automatic conv(input logic diag, input logic [2:0] src, input logic [23:0] val);
        @(negedge clock);
        convDone = 1'b1;
        convResult = '{isDiag: diag, source: src, value: val};
        @(negedge clock);
        convDone = 1'b0;
    endtask

    // Each call gives one rising edge of the raw comparator level on channel ch.
    task automatic comp_pulse(input int ch);
        @(negedge clock);
        deglitchedComp[ch] = ~deglitchedComp[ch];
        @(negedge clock);
        deglitchedComp[ch] = ~deglitchedComp[ch];
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        for (int a = 8'h4D; a <= 8'h58; a++) begin
            expect_rd(8'(a), 16'h0000);
        end
        expect_rd(8'h40, 16'h0000);
    endtask

    task automatic test_result;
        logic [15:0] up;
        logic [15:0] lo;
        conv(1'b0, 3'h2, 24'hAB_CDEF);
        expect_rd(8'h4D, 16'h02AB);
        // A newer result must not leak into the held low word of the pair.
        conv(1'b0, 3'h3, 24'h12_3456);
        expect_rd(8'h4E, 16'hCDEF);
        expect_rd(8'h4E, 16'h3456);
        conv(1'b1, 3'h5, 24'hFF_1234);
        expect_rd(8'h4D, 16'h0500);
        expect_rd(8'h4E, 16'h1234);
        // A result captured on the same edge as the upper read must not reach the pair.
        fork
            host.reg_read_pair(up, lo);
            conv(1'b0, 3'h1, 24'h65_4321);
        join
        check(up, 16'h0500);
        check(lo, 16'h1234);
        expect_rd(8'h4E, 16'h4321);
        expect_rd(8'h4D, 16'h0165);
    endtask

    task automatic test_tally;
        for (int ch = 0; ch < 4; ch++) begin
            @(negedge clock);
            countEnable[ch] = 1'b1;
            repeat (ch + 1) comp_pulse(ch);
            expect_rd(8'(8'h50 + 2 * ch), 16'(ch + 1));
            expect_rd(8'(8'h4F + 2 * ch), 16'h0000);
            countEnable[ch] = 1'b0;
            repeat (3) comp_pulse(ch);
            expect_rd(8'(8'h50 + 2 * ch), 16'(ch + 1));
        end
        // Invert is flipped while disabled, since the flip itself is an edge.
        comparator_invert[0] = 1'b1;
        @(negedge clock);
        countEnable[0] = 1'b1;
        comp_pulse(0);
        expect_rd(8'h50, 16'h0002);
        countEnable[0] = 1'b0;
    endtask

    task automatic test_supply;
        for (int k = 0; k < 6; k++) begin
            @(negedge clock);
            supplyFlags = rcs_supply_flags_t'(6'h01 << k);
            expect_rd(8'h57, 16'h0002 << k);
            supplyFlags = '0;
            host.reg_write(8'h57, 16'h0002 << k);
            expect_rd(8'h57, 16'h0000);
        end
        supplyFlags.analog_supply_high_side_fault = 1'b1;
        @(negedge clock);
        supplyFlags.analog_supply_high_side_fault = 1'b0;
        host.reg_write(8'h57, 16'hFF80);
        expect_rd(8'h57, 16'h0040);
        supplyFlags.digital_supply_fault = 1'b1;
        host.reg_write(8'h57, 16'h0004);
        expect_rd(8'h57, 16'h0044);
        supplyFlags.digital_supply_fault = 1'b0;
        host.reg_write(8'h57, 16'h007E);
        expect_rd(8'h57, 16'h0000);
    endtask

    task automatic test_cal_mem;
        logic [15:0] d;
        logic ok;
        @(negedge clock);
        calMemFault = 1'b1;
        @(negedge clock);
        calMemFault = 1'b0;
        host.reg_write(8'h57, 16'h0001);
        expect_rd(8'h57, 16'h0001);
        do_reset();
        expect_rd(8'h57, 16'h0000);
        calMemRefreshDone = 1'b0;
        host.reg_read(8'h50, d, ok);
        calMemRefreshDone = 1'b1;
        expect_rd(8'h57, 16'h0001);
        host.reg_write(8'h57, 16'h0001);
        expect_rd(8'h57, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        test_reset_values();
        test_result();
        test_tally();
        test_supply();
        test_cal_mem();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

endmodule // testbench

`default_nettype wire
